// file: bench/sfp_link_properties.sv
`timescale 1ns/1ns
// ****************************************
// link and status checks
// ****************************************
module sfp_link_properties #(
    parameter int unsigned SLEEP_CYCLES = 20
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic READY,
    input wire logic BUSY,
    input wire logic WRITE_UNLOCK,
    input wire logic DEEP_SLEEP
);
    logic [7:0] rel_q;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    // cycles since select release, saturating
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            rel_q <= 8'hFF;
        end else if (!cs_n) begin
            rel_q <= 8'h00;
        end else if (rel_q != 8'hFF) begin
            rel_q <= rel_q + 8'h01;
        end
    end
    property p_busy_start;
        $rose(BUSY) |-> cs_n && rel_q <= 8'h08;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy rose away from release");
    property p_unlock_drop;
        $rose(BUSY) |-> !WRITE_UNLOCK;
    endproperty
    a_unlock_drop: assert property (p_unlock_drop) else $error("unlock flag kept into cycle");
    property p_busy_hold;
        $rose(BUSY) |=> BUSY [*8];
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy cycle too short");
    property p_sleep_idle;
        DEEP_SLEEP |-> !BUSY;
    endproperty
    a_sleep_idle: assert property (p_sleep_idle) else $error("busy while asleep");
    property p_sleep_entry;
        $rose(DEEP_SLEEP) |-> cs_n && rel_q >= 8'(SLEEP_CYCLES);
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entered too early");
    property p_wake_exit;
        $fell(DEEP_SLEEP) |-> cs_n && rel_q <= 8'h08;
    endproperty
    a_wake_exit: assert property (p_wake_exit) else $error("sleep left away from release");
    property p_unlock_set;
        $rose(WRITE_UNLOCK) |-> cs_n && !BUSY && rel_q <= 8'h08;
    endproperty
    a_unlock_set: assert property (p_unlock_set) else $error("unlock flag set unexpectedly");
    property p_release_edge;
        $rose(cs_n) |-> !sck;
    endproperty
    a_release_edge: assert property (p_release_edge) else $error("release inside a bit");
    property p_ready_idle;
        READY |-> cs_n;
    endproperty
    a_ready_idle: assert property (p_ready_idle) else $error("select low while idle");
    c_busy: cover property ($rose(BUSY));
    c_sleep: cover property ($rose(DEEP_SLEEP));
    c_wake: cover property ($fell(DEEP_SLEEP));
endmodule : sfp_link_properties

// file: bench/testbench.sv
`timescale 1ns/1ns
// ****************************************
// bench for host and flash ends
// ****************************************
module testbench import sfp_pkg::*;;
    localparam int unsigned SLP = 20;
    localparam int LIMIT = 80000;
    logic CLOCK = 1'b0;
    logic RST = 1'b1;
    logic START = 1'b0;
    logic [7:0] OPCODE = 8'h00;
    logic WITH_ADDR = 1'b0;
    logic [23:0] ADDR = 24'h000000;
    logic [8:0] DATA_BYTES = 9'h000;
    logic [7:0] DATA_IN;
    logic DATA_TAKE, READY, BUSY, WRITE_UNLOCK, DEEP_SLEEP;
    logic [PAGES-1:0] PROTECT = 8'h00;
    logic [MEM_AW-1:0] PEEK_ADDR = 11'h000;
    logic [7:0] PEEK_DATA;
    logic [8:0] idx = 9'h000;
    logic [7:0] dbase = 8'h00;
    int mismatches = 0;
    int n_compared = 0;
    int cyc = 0;
    sfp_link_if u_sfp_link_if ();
    sfp_host #(.WAKE_HOLD_CYCLES(SLP)) u_sfp_host (.CLOCK(CLOCK), .RST(RST), .LINK(u_sfp_link_if.host),
        .START(START), .OPCODE(OPCODE), .WITH_ADDR(WITH_ADDR), .ADDR(ADDR), .DATA_BYTES(DATA_BYTES),
        .DATA_IN(DATA_IN), .DATA_TAKE(DATA_TAKE), .READY(READY));
    sfp_flash_dev #(.PROG_CYCLES(300), .PAGE_CLEAR_CYCLES(300), .BLOCK_CLEAR_CYCLES(1100),
        .SLEEP_CYCLES(SLP), .WAKE_CYCLES(SLP)) u_sfp_flash_dev (.CLOCK(CLOCK), .RST(RST),
        .LINK(u_sfp_link_if.dev), .PROTECT(PROTECT), .PEEK_ADDR(PEEK_ADDR), .PEEK_DATA(PEEK_DATA),
        .BUSY(BUSY), .WRITE_UNLOCK(WRITE_UNLOCK), .DEEP_SLEEP(DEEP_SLEEP));
    sfp_link_properties #(.SLEEP_CYCLES(SLP)) u_sfp_link_properties (.CLOCK(CLOCK), .RST(RST),
        .cs_n(u_sfp_link_if.cs_n), .sck(u_sfp_link_if.sck), .READY(READY), .BUSY(BUSY),
        .WRITE_UNLOCK(WRITE_UNLOCK), .DEEP_SLEEP(DEEP_SLEEP));
    // data byte k of a frame, with top bit inverted for k above 255
    assign DATA_IN = (idx[7:0] ^ {idx[8], 7'h00}) + dbase;
    // clock and data byte counter
    initial forever #4 CLOCK = ~CLOCK;
    always @(posedge CLOCK) begin
        if (DATA_TAKE === 1'b1) idx <= idx + 9'h001;
    end
    // hang guard
    always @(posedge CLOCK) begin
        cyc++;
        if (cyc >= LIMIT) begin
            mismatches++;
            $display("[ERR] %0t timeout", $time);
            complete_run();
        end
    end
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t byte %h want %h", $time, got, exp);
        end
    endtask : cmp
    task automatic cmpf(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t flag %b want %b", $time, got, exp);
        end
    endtask : cmpf
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge CLOCK);
            #1;
        end
    endtask : tick
    // one frame through the host end, back when idle again
    task automatic send(input logic [7:0] op, input logic wa, input logic [23:0] a, input logic [8:0] n);
        int t;
        OPCODE = op;
        WITH_ADDR = wa;
        ADDR = a;
        DATA_BYTES = n;
        idx = 9'h000;
        START = 1'b1;
        tick(1);
        START = 1'b0;
        for (t = 0; t < 40000 && READY !== 1'b1; t++) tick(1);
    endtask : send
    task automatic cmd(input logic [7:0] op, input logic wa, input logic [23:0] a, input logic [8:0] n,
        input logic expb);
        int t;
        send(op, wa, a, n);
        tick(2);
        cmpf(BUSY, expb);
        for (t = 0; t < 1500 && BUSY !== 1'b0; t++) tick(1);
    endtask : cmd
    task automatic pk(input logic [10:0] a, input logic [7:0] e);
        PEEK_ADDR = a;
        tick(2);
        cmp(PEEK_DATA, e);
    endtask : pk
    task automatic unl(input logic e);
        cmd(OP_WRITE_UNLOCK, 1'b0, 24'h000000, 9'h000, 1'b0);
        cmpf(WRITE_UNLOCK, e);
    endtask : unl
    task automatic t_prog();
        cmd(OP_PAGE_PROGRAM, 1'b1, 24'h000000, 9'h001, 1'b0);
        pk(11'h000, 8'hFF);
        unl(1'b1);
        cmd(OP_PAGE_PROGRAM, 1'b1, 24'hF000FE, 9'h004, 1'b1);
        cmpf(WRITE_UNLOCK, 1'b0);
        pk(11'h0FE, 8'h00);
        pk(11'h000, 8'h02);
        pk(11'h002, 8'hFF);
        unl(1'b1);
        dbase = 8'hFC;
        cmd(OP_PAGE_PROGRAM, 1'b1, 24'h000001, 9'h001, 1'b1);
        dbase = 8'h00;
        pk(11'h001, 8'h00);
        unl(1'b1);
        cmd(OP_PAGE_PROGRAM, 1'b1, 24'h000100, 9'h102, 1'b1);
        pk(11'h100, 8'h80);
        pk(11'h102, 8'h02);
        $display("program test done");
    endtask : t_prog
    task automatic t_clear();
        unl(1'b1);
        cmd(OP_PAGE_CLEAR, 1'b1, 24'h000057, 9'h000, 1'b1);
        pk(11'h0FE, 8'hFF);
        pk(11'h100, 8'h80);
        unl(1'b1);
        cmd(OP_PAGE_CLEAR, 1'b1, 24'h000157, 9'h001, 1'b0);
        PROTECT = 8'h02;
        cmd(OP_PAGE_CLEAR, 1'b1, 24'h000180, 9'h000, 1'b0);
        cmd(OP_BLOCK_CLEAR, 1'b1, 24'h000200, 9'h000, 1'b0);
        pk(11'h100, 8'h80);
        PROTECT = 8'h00;
        send(OP_BLOCK_CLEAR, 1'b1, 24'h0003FF, 9'h000);
        tick(2);
        cmpf(BUSY, 1'b1);
        cmd(OP_DEEP_SLEEP, 1'b0, 24'h000000, 9'h000, 1'b1);
        tick(40);
        cmpf(DEEP_SLEEP, 1'b0);
        pk(11'h100, 8'hFF);
        pk(11'h001, 8'hFF);
        $display("clear test done");
    endtask : t_clear
    task automatic t_sleep();
        cmd(OP_DEEP_SLEEP, 1'b0, 24'h000000, 9'h000, 1'b0);
        cmpf(DEEP_SLEEP, 1'b0);
        tick(30);
        cmpf(DEEP_SLEEP, 1'b1);
        unl(1'b0);
        cmd(OP_WAKE, 1'b1, 24'h000000, 9'h000, 1'b0);
        tick(30);
        cmpf(DEEP_SLEEP, 1'b1);
        cmd(OP_WAKE, 1'b0, 24'h000000, 9'h000, 1'b0);
        cmpf(DEEP_SLEEP, 1'b0);
        tick(10);
        unl(1'b1);
        cmd(OP_DEEP_SLEEP, 1'b0, 24'h000000, 9'h000, 1'b0);
        tick(30);
        RST = 1'b1;
        tick(2);
        RST = 1'b0;
        tick(2);
        cmpf(DEEP_SLEEP, 1'b0);
        cmpf(WRITE_UNLOCK, 1'b0);
        $display("sleep test done");
    endtask : t_sleep
    // main sequence
    initial begin
        repeat (2) @(posedge CLOCK);
        #1;
        RST = 1'b0;
        tick(2);
        t_prog();
        t_clear();
        t_sleep();
        complete_run();
    end
endmodule : testbench

// file: rtl/sfp_flash_dev.sv
`timescale 1ns/1ns
// Contract
// - program and clears need write-unlock flag set
// - programming only turns ones into zeros
// - host frames program: opcode, address, data
// - data past page end wraps within page
// - beyond 256 bytes, last 256 win
// - unsent bytes of page stay untouched
// - program runs only on byte-aligned select release
// - valid release starts timed cycle, busy set
// - write-unlock flag cleared during the cycle
// - protected page or sector is never altered
// - busy device rejects program, clear, sleep, wake
// - page clear writes FFh to whole page
// - clears need release right after address
// - block clear writes FFh to whole sector
// - top thirteen address bits are ignored
// - deep sleep needs release right after opcode
// - sleep entered after fixed entry delay
// - asleep, everything but wake is ignored
// - plain release gives standby, never sleep
// - wake with extra clocks is rejected
// - wake returns to standby after wake delay
// - reset always yields standby, flag clear
module sfp_flash_dev import sfp_pkg::*; #(
    parameter int unsigned PROG_CYCLES = PROG_CYC,
    parameter int unsigned PAGE_CLEAR_CYCLES = PAGE_CLEAR_CYC,
    parameter int unsigned BLOCK_CLEAR_CYCLES = BLOCK_CLEAR_CYC,
    parameter int unsigned SLEEP_CYCLES = SLEEP_ENTRY_CYC,
    parameter int unsigned WAKE_CYCLES = WAKE_CYC
) (
    input wire logic CLOCK,
    input wire logic RST,
    sfp_link_if.dev LINK,
    input wire logic [PAGES-1:0] PROTECT,
    input wire logic [MEM_AW-1:0] PEEK_ADDR,
    output logic [7:0] PEEK_DATA,
    output logic BUSY,
    output logic WRITE_UNLOCK,
    output logic DEEP_SLEEP
);
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_BUSY = 5'h02,
        ST_SLEEP_WAIT = 5'h04,
        ST_SLEEP = 5'h08,
        ST_WAKE_WAIT = 5'h10
    } sfp_state_t;
    sfp_state_t state_q;
    logic sel, bit_stb, bit_val, frame_end, byte_done;
    logic [2:0] bit_q, bytes_q;
    logic [7:0] shift_q, shifted, opcode_q, ptr_q;
    logic [23:0] addr_q;
    logic [7:0] pbuf [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] pvalid_q;
    logic [7:0] mem [MEM_BYTES];
    logic [1:0] job_q;
    logic [MEM_AW-1:0] base_q, span_q, idx_q;
    logic [TMR_W-1:0] tmr_q;
    logic wel_q, aligned, idle, page_prot, sect_prot, walking;
    logic go_prog, go_page, go_block, go_sleep, go_wake;

    // decides whether the opcode is a complete lone byte
    function automatic logic lone_op(input logic [7:0] op, input logic [2:0] nb, input logic al, input logic [7:0] want);
        lone_op = (op == want) && (nb == 3'h1) && al;
    endfunction : lone_op

    sfp_link_rx u_rx (
        .clk(CLOCK),
        .rst(RST),
        .cs_n_pin(LINK.cs_n),
        .sck_pin(LINK.sck),
        .mosi_pin(LINK.mosi),
        .sel(sel),
        .bit_stb(bit_stb),
        .bit_val(bit_val),
        .frame_end(frame_end)
    );

    // ****************************************
    // frame decode
    // ****************************************
    assign shifted = {shift_q[6:0], bit_val};
    assign byte_done = bit_stb && (bit_q == 3'h7);
    assign aligned = (bit_q == RESET_BITS);
    assign idle = (state_q == ST_IDLE);
    assign page_prot = PROTECT[addr_q[10:8]];
    assign sect_prot = |PROTECT[addr_q[10] * SECTOR_PAGES +: SECTOR_PAGES];

    // release checks, each gated by state; program and clears also by unlock
    assign go_prog = frame_end && idle && wel_q && aligned && (opcode_q == OP_PAGE_PROGRAM)
        && (bytes_q > 3'h4) && !page_prot;
    assign go_page = frame_end && idle && wel_q && aligned && (opcode_q == OP_PAGE_CLEAR)
        && (bytes_q == 3'h4) && !page_prot;
    assign go_block = frame_end && idle && wel_q && aligned && (opcode_q == OP_BLOCK_CLEAR)
        && (bytes_q == 3'h4) && !sect_prot;
    assign go_sleep = frame_end && idle && lone_op(opcode_q, bytes_q, aligned, OP_DEEP_SLEEP);
    assign go_wake = frame_end && (state_q == ST_SLEEP)
        && lone_op(opcode_q, bytes_q, aligned, OP_WAKE);

    // bit and byte counters, restarted by each release
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            bit_q <= RESET_BITS;
            bytes_q <= 3'h0;
            shift_q <= 8'h00;
        end else if (frame_end || !sel) begin
            bit_q <= RESET_BITS;
            bytes_q <= 3'h0;
        end else if (bit_stb) begin
            bit_q <= bit_q + 3'h1;
            shift_q <= shifted;
            if (byte_done && bytes_q != 3'h5) begin
                bytes_q <= bytes_q + 3'h1; // saturates once data bytes flow
            end
        end
    end

    // opcode and address capture, also while asleep so a wake can decode
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            opcode_q <= 8'h00;
            addr_q <= 24'h000000;
        end else if (byte_done && (idle || state_q == ST_SLEEP)) begin
            if (bytes_q == 3'h0) begin
                opcode_q <= shifted;
            end else if (bytes_q < 3'h4) begin
                addr_q <= {addr_q[15:0], shifted};
            end
        end
    end

    // page buffer: pointer wraps in the page, later bytes overwrite
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            ptr_q <= 8'h00;
            pvalid_q <= '0;
        end else if (idle && bit_stb && bytes_q == 3'h0 && bit_q == RESET_BITS) begin
            pvalid_q <= '0;
        end else if (idle && byte_done && bytes_q == 3'h3) begin
            ptr_q <= shifted; // start column
        end else if (idle && byte_done && bytes_q > 3'h3 && opcode_q == OP_PAGE_PROGRAM) begin
            pvalid_q[ptr_q] <= 1'b1;
            ptr_q <= ptr_q + 8'h01;
        end
    end

    // buffer data lanes, no reset needed
    always_ff @(posedge CLOCK) begin
        if (idle && byte_done && bytes_q > 3'h3 && opcode_q == OP_PAGE_PROGRAM) begin
            pbuf[ptr_q] <= shifted;
        end
    end

    // ****************************************
    // write-unlock flag and power states
    // ****************************************
    // set on a lone unlock opcode, cleared when a cycle starts
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            wel_q <= 1'b0;
        end else if (go_prog || go_page || go_block) begin
            wel_q <= 1'b0;
        end else if (frame_end && idle && lone_op(opcode_q, bytes_q, aligned, OP_WRITE_UNLOCK)) begin
            wel_q <= 1'b1;
        end
    end
    assign walking = (state_q == ST_BUSY) && (idx_q < span_q); // span not yet fully touched
    // state sequence with delay timer
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            state_q <= ST_IDLE;
            tmr_q <= '0;
            job_q <= JOB_PROG;
            base_q <= '0;
            span_q <= '0;
            idx_q <= '0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    idx_q <= '0;
                    if (go_prog) begin
                        state_q <= ST_BUSY;
                        job_q <= JOB_PROG;
                        base_q <= {addr_q[10:8], 8'h00};
                        span_q <= PAGE_SPAN;
                        tmr_q <= TMR_W'(PROG_CYCLES - 1);
                    end else if (go_page) begin
                        state_q <= ST_BUSY;
                        job_q <= JOB_PAGE;
                        base_q <= {addr_q[10:8], 8'h00};
                        span_q <= PAGE_SPAN;
                        tmr_q <= TMR_W'(PAGE_CLEAR_CYCLES - 1);
                    end else if (go_block) begin
                        state_q <= ST_BUSY;
                        job_q <= JOB_BLOCK;
                        base_q <= {addr_q[10], 10'h000};
                        span_q <= SECTOR_SPAN;
                        tmr_q <= TMR_W'(BLOCK_CLEAR_CYCLES - 1);
                    end else if (go_sleep) begin
                        state_q <= ST_SLEEP_WAIT;
                        tmr_q <= TMR_W'(SLEEP_CYCLES - 1);
                    end
                end
                ST_BUSY: begin
                    if (walking) begin
                        idx_q <= idx_q + 11'h001;
                    end
                    if (tmr_q != '0) begin
                        tmr_q <= tmr_q - 1'b1;
                    end else if (!walking) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_SLEEP_WAIT: begin
                    if (tmr_q != '0) begin
                        tmr_q <= tmr_q - 1'b1;
                    end else begin
                        state_q <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (go_wake) begin
                        state_q <= ST_WAKE_WAIT;
                        tmr_q <= TMR_W'(WAKE_CYCLES - 1);
                    end
                end
                ST_WAKE_WAIT: begin
                    if (tmr_q != '0) begin
                        tmr_q <= tmr_q - 1'b1;
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // array update and observation
    // ****************************************
    // one byte per clock while the cycle walks its span
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < MEM_BYTES; i++) begin
                mem[i] <= ERASED_BYTE;
            end
        end else if (walking) begin
            if (job_q == JOB_PROG) begin
                if (pvalid_q[idx_q[7:0]]) begin
                    mem[base_q + idx_q] <= mem[base_q + idx_q] & pbuf[idx_q[7:0]];
                end
            end else begin
                mem[base_q + idx_q] <= ERASED_BYTE;
            end
        end
    end

    // registered peek port
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            PEEK_DATA <= 8'h00;
        end else begin
            PEEK_DATA <= mem[PEEK_ADDR];
        end
    end

    assign BUSY = (state_q == ST_BUSY);
    assign WRITE_UNLOCK = wel_q;
    assign DEEP_SLEEP = (state_q == ST_SLEEP);
endmodule : sfp_flash_dev

// file: rtl/sfp_host.sv
`timescale 1ns/1ns
// ****************************************
// host end: frames one instruction per start
// ****************************************
module sfp_host import sfp_pkg::*; #(
    parameter int unsigned WAKE_HOLD_CYCLES = WAKE_CYC
) (
    input wire logic CLOCK,
    input wire logic RST,
    sfp_link_if.host LINK,
    input wire logic START,
    input wire logic [7:0] OPCODE,
    input wire logic WITH_ADDR,
    input wire logic [23:0] ADDR,
    input wire logic [8:0] DATA_BYTES,
    input wire logic [7:0] DATA_IN,
    output logic DATA_TAKE,
    output logic READY
);
    typedef enum logic [4:0] {
        H_IDLE = 5'h01,
        H_LOW = 5'h02,
        H_HIGH = 5'h04,
        H_END = 5'h08,
        H_GAP = 5'h10
    } sfp_hstate_t;

    sfp_hstate_t st_q;
    logic cs_q;
    logic sck_q;
    logic mosi_q;
    logic [7:0] div_q;
    logic [7:0] sh_q;
    logic [2:0] bitn_q;
    logic [9:0] left_q;
    logic [1:0] aleft_q;
    logic [23:0] addr_q;
    logic [7:0] op_q;
    logic [TMR_W-1:0] hold_q;
    logic last_edge;
    logic [7:0] next_byte;

    assign last_edge = (st_q == H_HIGH) && (div_q == 8'h00) && (bitn_q == 3'h7) && (left_q != 10'h000);
    assign DATA_TAKE = last_edge && (aleft_q == 2'h0);
    assign next_byte = (aleft_q != 2'h0) ? addr_q[23:16] : DATA_IN;
    assign READY = (st_q == H_IDLE);

    // divider-made serial clock, bits change while it is low
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            st_q <= H_IDLE;
            cs_q <= 1'b1;
            sck_q <= 1'b0;
            mosi_q <= 1'b0;
            div_q <= 8'h00;
            sh_q <= 8'h00;
            bitn_q <= 3'h0;
            left_q <= 10'h000;
            aleft_q <= 2'h0;
            addr_q <= 24'h000000;
            op_q <= 8'h00;
            hold_q <= '0;
        end else begin
            unique case (st_q)
                H_IDLE: begin
                    if (START) begin
                        st_q <= H_LOW;
                        cs_q <= 1'b0;
                        sh_q <= OPCODE;
                        op_q <= OPCODE;
                        mosi_q <= OPCODE[7];
                        bitn_q <= 3'h0;
                        addr_q <= ADDR;
                        aleft_q <= WITH_ADDR ? 2'h3 : 2'h0;
                        left_q <= {1'b0, DATA_BYTES} + (WITH_ADDR ? 10'h003 : 10'h000);
                        div_q <= SCK_HALF_CYC - 8'h01;
                    end
                end
                H_LOW: begin
                    div_q <= div_q - 8'h01;
                    if (div_q == 8'h00) begin
                        sck_q <= 1'b1;
                        div_q <= SCK_HALF_CYC - 8'h01;
                        st_q <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    div_q <= div_q - 8'h01;
                    if (div_q == 8'h00) begin
                        sck_q <= 1'b0;
                        div_q <= SCK_HALF_CYC - 8'h01;
                        st_q <= H_LOW;
                        bitn_q <= bitn_q + 3'h1;
                        if (bitn_q != 3'h7) begin
                            sh_q <= {sh_q[6:0], 1'b0};
                            mosi_q <= sh_q[6];
                        end else if (left_q == 10'h000) begin
                            st_q <= H_END; // release on the byte boundary
                        end else begin
                            sh_q <= next_byte;
                            mosi_q <= next_byte[7];
                            left_q <= left_q - 10'h001;
                            if (aleft_q != 2'h0) begin
                                aleft_q <= aleft_q - 2'h1;
                                addr_q <= {addr_q[15:0], 8'h00};
                            end
                        end
                    end
                end
                H_END: begin
                    div_q <= div_q - 8'h01;
                    if (div_q == 8'h00) begin
                        cs_q <= 1'b1;
                        st_q <= H_GAP;
                        hold_q <= (op_q == OP_WAKE) ? TMR_W'(WAKE_HOLD_CYCLES) : FRAME_GAP_CYC;
                    end
                end
                H_GAP: begin
                    hold_q <= hold_q - 1'b1;
                    if (hold_q == '0) begin
                        st_q <= H_IDLE;
                    end
                end
            endcase
        end
    end

    assign LINK.cs_n = cs_q;
    assign LINK.sck = sck_q;
    assign LINK.mosi = mosi_q;
endmodule : sfp_host

// file: rtl/sfp_link_if.sv
`timescale 1ns/1ns
// ****************************************
// serial link between host and flash
// ****************************************
interface sfp_link_if;
    logic cs_n;
    logic sck;
    logic mosi;
    modport dev (input cs_n, input sck, input mosi);
    modport host (output cs_n, output sck, output mosi);
endinterface : sfp_link_if

// file: rtl/sfp_link_rx.sv
`timescale 1ns/1ns
// ****************************************
// pin synchroniser and edge finder
// ****************************************
module sfp_link_rx (
    input wire logic clk,
    input wire logic rst,
    input wire logic cs_n_pin,
    input wire logic sck_pin,
    input wire logic mosi_pin,
    output logic sel,
    output logic bit_stb,
    output logic bit_val,
    output logic frame_end
);
    logic [2:0] s1_q;
    logic [2:0] s2_q;
    logic [1:0] old_q;

    // two flops on every pin, first stage read only by second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= 3'h7;
            s2_q <= 3'h7;
        end else begin
            s1_q <= {cs_n_pin, sck_pin, mosi_pin};
            s2_q <= s1_q;
        end
    end

    // previous synced chip select and clock for edge finding
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            old_q <= 2'h3;
        end else begin
            old_q <= s2_q[2:1];
        end
    end

    assign sel = ~s2_q[2];
    assign bit_stb = ~s2_q[2] & s2_q[1] & ~old_q[0]; // rising serial clock while selected
    assign bit_val = s2_q[0];
    assign frame_end = s2_q[2] & ~old_q[1];
endmodule : sfp_link_rx

// file: rtl/sfp_pkg.sv
// ****************************************
// constants shared by both link ends
// ****************************************
package sfp_pkg;
    // opcodes of the handled instructions
    localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_PAGE_CLEAR = 8'hDB;
    localparam logic [7:0] OP_BLOCK_CLEAR = 8'hD8;
    localparam logic [7:0] OP_DEEP_SLEEP = 8'hB9;
    localparam logic [7:0] OP_WAKE = 8'hAB;
    // array geometry of the modelled slice
    localparam int unsigned PAGE_BYTES = 256;
    localparam int unsigned PAGES = 8;
    localparam int unsigned SECTOR_PAGES = 4;
    localparam int unsigned MEM_BYTES = PAGE_BYTES * PAGES;
    localparam int unsigned MEM_AW = 11;
    localparam logic [MEM_AW-1:0] PAGE_SPAN = 11'h100;
    localparam logic [MEM_AW-1:0] SECTOR_SPAN = 11'h400;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    // job kinds of a self-timed cycle
    localparam logic [1:0] JOB_PROG = 2'h0;
    localparam logic [1:0] JOB_PAGE = 2'h1;
    localparam logic [1:0] JOB_BLOCK = 2'h2;
    // time base
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned PROG_TIME_US = 1200;
    localparam int unsigned PAGE_CLEAR_TIME_US = 10000;
    localparam int unsigned BLOCK_CLEAR_TIME_US = 5000;
    localparam int unsigned SLEEP_ENTRY_DELAY_US = 3;
    localparam int unsigned WAKE_DELAY_US = 3;
    localparam int unsigned PROG_CYC = PROG_TIME_US * CLK_MHZ;
    localparam int unsigned PAGE_CLEAR_CYC = PAGE_CLEAR_TIME_US * CLK_MHZ;
    localparam int unsigned BLOCK_CLEAR_CYC = BLOCK_CLEAR_TIME_US * CLK_MHZ;
    localparam int unsigned SLEEP_ENTRY_CYC = SLEEP_ENTRY_DELAY_US * CLK_MHZ;
    localparam int unsigned WAKE_CYC = WAKE_DELAY_US * CLK_MHZ;
    localparam int unsigned TMR_W = 24;
    // host side link timing and device bit counter start
    localparam logic [7:0] SCK_HALF_CYC = 8'h08;
    localparam logic [TMR_W-1:0] FRAME_GAP_CYC = 24'h000004;
    localparam logic [2:0] RESET_BITS = 3'h0;
endpackage : sfp_pkg
